// ===== fpsfr_defines.vh
/*
 * Register indices, field positions and reset values of the F-page
 * register bank. Byte address on the bus is four times the index.
 * Assumes inclusion by bare name from the bank's design files.
 */
`ifndef FPSFR_DEFINES_VH
`define FPSFR_DEFINES_VH

// Register indices
`define FPSFR_IDX_T1LO      8'h00
`define FPSFR_IDX_PADIR     8'h05
`define FPSFR_IDX_PBDIR     8'h06
`define FPSFR_IDX_PULL      8'h09
`define FPSFR_IDX_PS0       8'h0A
`define FPSFR_IDX_PBOD      8'h0C
`define FPSFR_IDX_CMP       8'h0E
`define FPSFR_IDX_PCON      8'h0F
`define FPSFR_IDX_T1HI      8'h19

// Reset values
`define FPSFR_RST_PADIR     8'hFF
`define FPSFR_RST_PBDIR     6'h3F
`define FPSFR_RST_PULL      8'hFF
`define FPSFR_RST_PS0       8'hFF
`define FPSFR_RST_PBOD      6'h00
`define FPSFR_RST_CMP       8'h0C
`define FPSFR_RST_GIE       1'h0
`define FPSFR_RST_GP5       1'h0
`define FPSFR_RST_LVDS      3'h7
`define FPSFR_RST_GP1       1'h0
`define FPSFR_RST_TIMER_ZERO_RUN      1'h1
`define FPSFR_RST_T1HI      2'h0
`define FPSFR_RST_T1        10'h000

// Field positions
`define FPSFR_PCON_GIE      7
`define FPSFR_PCON_LVD      6
`define FPSFR_PCON_GP5      5
`define FPSFR_PCON_LVDS_HI  4
`define FPSFR_PCON_LVDS_LO  2
`define FPSFR_PCON_GP1      1
`define FPSFR_PCON_TIMER_ZERO_RUN     0
`define FPSFR_CMP_PS_HI     7
`define FPSFR_CMP_PS_LO     4
`define FPSFR_CMP_VS_HI     3
`define FPSFR_CMP_VS_LO     0
`define FPSFR_PULL_PIN5     5
`define FPSFR_T1HI_HI       5
`define FPSFR_T1HI_LO       4

// Bus
`define FPSFR_HTRANS_ACT    1
`define FPSFR_HRESP_OKAY    1'h0

`endif

// ===== fpsfr_prescaler.v
/*
 * Prescaler0 counter whose live value the bank shows read-only.
 * Assumes tick is a one-cycle enable from logic on hclk.
 */
`timescale 1ns/1ps
`include "fpsfr_defines.vh"

module fpsfr_prescaler #(
  parameter WIDTH = 8
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             run,
  input  wire             tick,
  output reg  [WIDTH-1:0] count_q
);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= `FPSFR_RST_PS0;
    end else if (run && tick) begin
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ===== fpsfr_timer1.v
/*
 * Ten-bit down-counting timer1 core with its reload register.
 * Assumes load and tick are one-cycle enables on hclk; load wins.
 */
`timescale 1ns/1ps
`include "fpsfr_defines.vh"

module fpsfr_timer1 #(
  parameter WIDTH = 10
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             load,
  input  wire [WIDTH-1:0] load_val,
  input  wire             run,
  input  wire             tick,
  output reg  [WIDTH-1:0] count_q
);

  reg [WIDTH-1:0] reload_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_q <= `FPSFR_RST_T1;
      count_q  <= `FPSFR_RST_T1;
    end else if (load) begin
      reload_q <= load_val;
      count_q  <= load_val;
    end else if (run && tick) begin
      // Underflow restarts from the reload value
      if (count_q == {WIDTH{1'b0}}) begin
        count_q <= reload_q;
      end else begin
        count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ===== fpsfr_bank.v
/*
 * F-page special function register bank on an AHB-Lite slave port:
 * port directions, pulls, open-drain, comparator selection, power
 * control, prescaler0 view and timer1 low/high byte access.
 * Assumes a single-master AHB-Lite bus on hclk, word transfers, and
 * that the core's instruction strobes and ticks are on hclk.
 */
`timescale 1ns/1ps
`include "fpsfr_defines.vh"

// Operation
// [RULE1] Port A direction: set input, clear output
// [RULE2] Port B direction: six bits, set input
// [RULE3] Port A pull-ups active low, except pin5
// [RULE4] Pin5 bit controls pull-down, active low
// [RULE5] Software avoids pull-ups on crystal pins
// [RULE6] Prescaler0 count read-only, live, resets ones
// [RULE7] Port B open-drain bits, reset cleared
// [RULE8] Zero voltage select means pad-to-pad mode
// [RULE9] Nonzero select gives code/16 supply reference
// [RULE10] Pad-to-voltage: codes 0-3 pick pad 0-3
// [RULE11] Pad-to-pad: fixed four pin pair combinations
// [RULE12] Timer0 enable bit runs timer0, resets set
// [RULE13] Three-bit low-voltage threshold, reset 111
// [RULE14] Low-voltage flag read-only status bit six
// [RULE15] Global interrupt enable gates all, resets clear
// [RULE16] Enable/disable instructions set/clear interrupt enable
// [RULE17] Two spare read/write bits, reset clear
// [RULE18] Timer1 low read returns live count
// [RULE19] Timer1 low write loads ten-bit count
// [RULE20] High-byte bits hold/return timer1 bits 9:8
// [RULE21] Unused pad codes disconnect; reserved read zero
module fpsfr_bank #(
  parameter T1_WIDTH  = 10,
  parameter PS0_WIDTH = 8
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire        irq_enable_instr,
  input  wire        irq_disable_instr,
  input  wire        ps0_tick,
  input  wire        t1_run,
  input  wire        t1_tick,
  input  wire        low_voltage_raw,
  output reg  [7:0]  port_a_direction,
  output reg  [5:0]  port_b_direction,
  output reg  [7:0]  port_a_pullup_en,
  output reg         pin5_pulldown_en,
  output reg  [5:0]  port_b_open_drain,
  output reg         pad_to_pad_mode,
  output reg  [3:0]  cmp_ref_level,
  output reg  [3:0]  cmp_noninv_pad,
  output reg  [3:0]  cmp_inv_pad,
  output reg  [2:0]  low_voltage_threshold,
  output reg         global_irq_enable,
  output reg         timer_zero_run
);

  // Register state
  reg [7:0]           padir_q;
  reg [5:0]           pbdir_q;
  reg [7:0]           pull_q;
  reg [5:0]           pbod_q;
  reg [7:0]           cmp_q;
  reg                 gie_q;
  reg                 gp5_q;
  reg [2:0]           lvds_q;
  reg                 gp1_q;
  reg                 timer_zero_run_q;
  reg [1:0]           t1hi_q;
  reg                 lvd_meta_q;
  reg                 lvd_sync_q;

  // Bus state
  reg                 wr_pend_q;
  reg                 rd_pend_q;
  reg [7:0]           idx_q;

  wire [T1_WIDTH-1:0]  t1_count;
  wire [PS0_WIDTH-1:0] ps0_count;
  wire                 addr_take;
  wire                 wr_now;
  wire [7:0]           wdat;
  wire [3:0]           vs;
  wire [3:0]           ps;
  wire [7:0]           pcon_rd;
  reg  [31:0]          rd_mux;
  wire                 wr_pcon;
  wire                 t1_load;

  assign addr_take = hsel && hready && htrans[`FPSFR_HTRANS_ACT];
  assign wr_now    = wr_pend_q;
  assign wdat      = hwdata[7:0];
  assign vs        = cmp_q[`FPSFR_CMP_VS_HI:`FPSFR_CMP_VS_LO];
  assign ps        = cmp_q[`FPSFR_CMP_PS_HI:`FPSFR_CMP_PS_LO];

  // One-hot pad pick for pad-to-voltage mode
  function [3:0] p2v_pad;
    input [3:0] code;
    begin
      if (code[3:2] == 2'b00) begin
        p2v_pad = 4'h1 << code[1:0];
      end else begin
        p2v_pad = 4'h0;
      end
    end
  endfunction

  // One-hot pad pick for pad-to-pad mode; inv swaps the pin pair
  function [3:0] p2p_pad;
    input [3:0] code;
    input       inv;
    begin
      if (code[3:2] == 2'b00) begin
        p2p_pad = 4'h1 << {code[1], code[0] ^ inv};
      end else begin
        p2p_pad = 4'h0;
      end
    end
  endfunction

  // Register index match for the current data phase
  function idx_is;
    input [7:0] idx;
    input [7:0] want;
    begin
      idx_is = (idx == want);
    end
  endfunction

  assign wr_pcon = wr_now && idx_is(idx_q, `FPSFR_IDX_PCON);
  assign t1_load = wr_now && idx_is(idx_q, `FPSFR_IDX_T1LO);

  // Bus address and data phases
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= `FPSFR_HRESP_OKAY;
      hrdata    <= 32'h0000_0000;
    end else begin
      hresp <= `FPSFR_HRESP_OKAY;
      if (rd_pend_q) begin
        // Second read cycle: earlier writes have landed
        hrdata    <= rd_mux;
        hreadyout <= 1'b1;
        rd_pend_q <= 1'b0;
      end else begin
        wr_pend_q <= addr_take && hwrite;
        if (addr_take) begin
          idx_q <= haddr[9:2];
        end
        if (addr_take && !hwrite) begin
          rd_pend_q <= 1'b1;
          hreadyout <= 1'b0;
        end
      end
    end
  end

  // Low-voltage detector output from the analog side
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvd_meta_q <= 1'b0;
      lvd_sync_q <= 1'b0;
    end else begin
      lvd_meta_q <= low_voltage_raw;
      lvd_sync_q <= lvd_meta_q;
    end
  end

  // Register writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      padir_q <= `FPSFR_RST_PADIR;
      pbdir_q <= `FPSFR_RST_PBDIR;
      pull_q  <= `FPSFR_RST_PULL;
      pbod_q  <= `FPSFR_RST_PBOD;
      cmp_q   <= `FPSFR_RST_CMP;
      gp5_q   <= `FPSFR_RST_GP5;
      lvds_q  <= `FPSFR_RST_LVDS;
      gp1_q   <= `FPSFR_RST_GP1;
      timer_zero_run_q  <= `FPSFR_RST_TIMER_ZERO_RUN;
      t1hi_q  <= `FPSFR_RST_T1HI;
    end else if (wr_now) begin
      if (idx_q == `FPSFR_IDX_PADIR) begin
        // [RULE1] all eight direction bits
        padir_q <= wdat;
      end else if (idx_q == `FPSFR_IDX_PBDIR) begin
        // [RULE2] six direction bits
        pbdir_q <= wdat[5:0];
      end else if (idx_q == `FPSFR_IDX_PULL) begin
        pull_q <= wdat;
      end else if (idx_q == `FPSFR_IDX_PBOD) begin
        // [RULE7] six open-drain bits
        pbod_q <= wdat[5:0];
      end else if (idx_q == `FPSFR_IDX_CMP) begin
        cmp_q <= wdat;
      end else if (idx_q == `FPSFR_IDX_PCON) begin
        // [RULE17] spare bits stored only
        gp5_q  <= wdat[`FPSFR_PCON_GP5];
        gp1_q  <= wdat[`FPSFR_PCON_GP1];
        // [RULE13] threshold select
        lvds_q <= wdat[`FPSFR_PCON_LVDS_HI:`FPSFR_PCON_LVDS_LO];
        // [RULE12] timer0 run bit
        timer_zero_run_q <= wdat[`FPSFR_PCON_TIMER_ZERO_RUN];
      end else if (idx_q == `FPSFR_IDX_T1HI) begin
        // [RULE20] upper load bits
        t1hi_q <= wdat[`FPSFR_T1HI_HI:`FPSFR_T1HI_LO];
      end
    end
  end

  // Interrupt enable: instructions win over a bus write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gie_q <= `FPSFR_RST_GIE;
    end else if (irq_enable_instr) begin
      // [RULE16] enable instruction sets
      gie_q <= 1'b1;
    end else if (irq_disable_instr) begin
      // [RULE16] disable instruction clears
      gie_q <= 1'b0;
    end else if (wr_pcon) begin
      gie_q <= wdat[`FPSFR_PCON_GIE];
    end
  end

  // [RULE14] flag not writable, synced input
  assign pcon_rd = {gie_q, lvd_sync_q, gp5_q, lvds_q, gp1_q, timer_zero_run_q};

  // Read data select; reserved bits read zero
  always @* begin
    // [RULE21] reserved bits zero
    rd_mux = 32'h0000_0000;
    if (idx_q == `FPSFR_IDX_T1LO) begin
      // [RULE18] live count low byte
      rd_mux[7:0] = t1_count[7:0];
    end else if (idx_q == `FPSFR_IDX_PADIR) begin
      rd_mux[7:0] = padir_q;
    end else if (idx_q == `FPSFR_IDX_PBDIR) begin
      rd_mux[5:0] = pbdir_q;
    end else if (idx_q == `FPSFR_IDX_PULL) begin
      rd_mux[7:0] = pull_q;
    end else if (idx_q == `FPSFR_IDX_PS0) begin
      // [RULE6] live prescaler value
      rd_mux[7:0] = ps0_count[7:0];
    end else if (idx_q == `FPSFR_IDX_PBOD) begin
      rd_mux[5:0] = pbod_q;
    end else if (idx_q == `FPSFR_IDX_CMP) begin
      rd_mux[7:0] = cmp_q;
    end else if (idx_q == `FPSFR_IDX_PCON) begin
      // [RULE16] state read path
      rd_mux[7:0] = pcon_rd;
    end else if (idx_q == `FPSFR_IDX_T1HI) begin
      // [RULE20] live count bits 9:8
      rd_mux[`FPSFR_T1HI_HI:`FPSFR_T1HI_LO] = t1_count[T1_WIDTH-1:T1_WIDTH-2];
    end
  end

  fpsfr_prescaler #(
    .WIDTH (PS0_WIDTH)
  ) u_ps0 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (timer_zero_run_q),
    .tick    (ps0_tick),
    .count_q (ps0_count)
  );

  // [RULE19] low-byte write loads count
  fpsfr_timer1 #(
    .WIDTH (T1_WIDTH)
  ) u_t1 (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (t1_load),
    .load_val ({t1hi_q, wdat}),
    .run      (t1_run),
    .tick     (t1_tick),
    .count_q  (t1_count)
  );

  // Registered control outputs, one cycle behind the registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_direction      <= `FPSFR_RST_PADIR;
      port_b_direction      <= `FPSFR_RST_PBDIR;
      port_a_pullup_en      <= 8'h00;
      pin5_pulldown_en      <= 1'b0;
      port_b_open_drain     <= `FPSFR_RST_PBOD;
      pad_to_pad_mode       <= 1'b0;
      cmp_ref_level         <= 4'h0;
      cmp_noninv_pad        <= 4'h0;
      cmp_inv_pad           <= 4'h0;
      low_voltage_threshold <= `FPSFR_RST_LVDS;
      global_irq_enable     <= `FPSFR_RST_GIE;
      timer_zero_run        <= `FPSFR_RST_TIMER_ZERO_RUN;
    end else begin
      // [RULE1] set bit means input
      port_a_direction <= padir_q;
      // [RULE2] set bit means input
      port_b_direction <= pbdir_q;
      // [RULE3] cleared bit enables pull-up
      port_a_pullup_en <= ~pull_q & 8'hDF;
      // [RULE4] cleared bit enables pull-down
      pin5_pulldown_en <= ~pull_q[`FPSFR_PULL_PIN5];
      // [RULE7] set bit means open-drain
      port_b_open_drain <= pbod_q;
      // [RULE8] zero select is pad-to-pad
      pad_to_pad_mode <= (vs == 4'h0);
      // [RULE9] reference is code sixteenths
      cmp_ref_level <= vs;
      if (vs == 4'h0) begin
        // [RULE11] pin pair per code
        cmp_noninv_pad <= p2p_pad(ps, 1'b0);
        cmp_inv_pad    <= p2p_pad(ps, 1'b1);
      end else begin
        // [RULE10] single pad, reference on inverting
        cmp_noninv_pad <= p2v_pad(ps);
        cmp_inv_pad    <= 4'h0;
      end
      // [RULE13] threshold to detector
      low_voltage_threshold <= lvds_q;
      // [RULE15] enable gates all interrupts
      global_irq_enable <= gie_q;
      // [RULE12] timer0 run
      timer_zero_run <= timer_zero_run_q;
    end
  end

  // [RULE21] other pad codes give all-zero selects above

endmodule

// ===== fpsfr_bank_props.sv
/*
 * Bus and control-output checks for the F-page register bank.
 * Assumes hready is tied to hreadyout and hclk is the only clock.
 */
`timescale 1ns/1ps
module fpsfr_bank_props (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hready,
  input logic        hreadyout,
  input logic        hresp,
  input logic [31:0] hrdata,
  input logic        irq_enable_instr,
  input logic        irq_disable_instr,
  input logic [7:0]  port_a_pullup_en,
  input logic        pad_to_pad_mode,
  input logic [3:0]  cmp_ref_level,
  input logic [3:0]  cmp_noninv_pad,
  input logic [3:0]  cmp_inv_pad,
  input logic        global_irq_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_take;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence wr_take;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  AST_RD_WAIT: assert property (rd_take |=> rd_wait)
    else $error("read data phase not two cycles");
  AST_WR_NOWAIT: assert property (wr_take |=> hreadyout)
    else $error("write data phase stalled");
  AST_HI_ZERO: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_PIN5_PULLUP: assert property (port_a_pullup_en[5] == 1'b0)
    else $error("pull-up on pin five");
  AST_P2P_REF: assert property (pad_to_pad_mode |-> cmp_ref_level == 4'h0)
    else $error("reference active in pad-to-pad mode");
  AST_P2V_INV: assert property (!pad_to_pad_mode |-> cmp_inv_pad == 4'h0)
    else $error("inverting pad used with reference");
  AST_ONEHOT: assert property ($onehot0(cmp_noninv_pad) && $onehot0(cmp_inv_pad))
    else $error("more than one pad selected");
  AST_P2P_PAIR: assert property (pad_to_pad_mode |-> cmp_inv_pad ==
    {cmp_noninv_pad[2], cmp_noninv_pad[3], cmp_noninv_pad[0], cmp_noninv_pad[1]})
    else $error("pad pair mismatch");
  AST_ENI: assert property (irq_enable_instr |-> ##2 global_irq_enable)
    else $error("enable instruction ignored");
  AST_IRQ_DISABLE_INSTR: assert property (irq_disable_instr && !irq_enable_instr |->
    ##2 !global_irq_enable)
    else $error("disable instruction ignored");
endmodule

bind fpsfr_bank fpsfr_bank_props u_fpsfr_bank_props (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .hrdata, .irq_enable_instr, .irq_disable_instr, .port_a_pullup_en,
  .pad_to_pad_mode, .cmp_ref_level, .cmp_noninv_pad, .cmp_inv_pad,
  .global_irq_enable
);

// ===== test_fpsfr_bank.sv
/*
 * Self-checking bench for the F-page register bank over AHB-Lite.
 * Assumes the checker binds itself; hsize is tied to word size.
 */
`timescale 1ns/1ps
`include "fpsfr_defines.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module test_fpsfr_bank;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        irq_enable_instr = 1'b0;
  logic        irq_disable_instr = 1'b0;
  logic        ps0_tick = 1'b0;
  logic        t1_run = 1'b0;
  logic        t1_tick = 1'b0;
  logic        low_voltage_raw = 1'b0;
  wire         hreadyout, hresp, pin5_pulldown_en, pad_to_pad_mode;
  wire         global_irq_enable, timer_zero_run;
  wire  [31:0] hrdata;
  wire  [7:0]  port_a_direction, port_a_pullup_en;
  wire  [5:0]  port_b_direction, port_b_open_drain;
  wire  [3:0]  cmp_ref_level, cmp_noninv_pad, cmp_inv_pad;
  wire  [2:0]  low_voltage_threshold;
  int          error_cnt = 0;
  int          n_tests = 0;

  fpsfr_bank u_fpsfr_bank (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq_enable_instr,
    .irq_disable_instr, .ps0_tick, .t1_run, .t1_tick, .low_voltage_raw,
    .port_a_direction, .port_b_direction, .port_a_pullup_en, .pin5_pulldown_en,
    .port_b_open_drain, .pad_to_pad_mode, .cmp_ref_level, .cmp_noninv_pad,
    .cmp_inv_pad, .low_voltage_threshold, .global_irq_enable, .timer_zero_run
  );

  always #5 hclk = ~hclk;

  task automatic wt;
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 99);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      $display("ERROR hready exp 1 got %b", hreadyout);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {22'h0, a, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    `CHK("read data", e, r)
  endtask
  task automatic st;
    repeat (2) @(posedge hclk);
  endtask
  task automatic instr(input logic e, d);
    irq_enable_instr <= e;
    irq_disable_instr <= d;
    @(posedge hclk);
    irq_enable_instr <= 1'b0;
    irq_disable_instr <= 1'b0;
    st();
  endtask

  task automatic t_reset;
    `CHK("a dir", 8'hFF, port_a_direction)
    `CHK("t0 run", 1'b1, timer_zero_run)
    `CHK("lv thr", 3'h7, low_voltage_threshold)
    `CHK("gie", 1'b0, global_irq_enable)
    `CHK("ref", 4'hC, cmp_ref_level)
    rd(`FPSFR_IDX_PADIR, 32'hFF);
    rd(`FPSFR_IDX_PULL, 32'hFF);
    rd(`FPSFR_IDX_PS0, 32'hFF);
    rd(`FPSFR_IDX_PBOD, 32'h00);
    rd(`FPSFR_IDX_CMP, 32'h0C);
    rd(`FPSFR_IDX_PCON, 32'h1D);
    $display("test reset done");
  endtask
  task automatic t_rw;
    wr(`FPSFR_IDX_PADIR, 8'h5A);
    wr(`FPSFR_IDX_PBDIR, 8'hD5);
    wr(`FPSFR_IDX_PBOD, 8'hEA);
    wr(`FPSFR_IDX_PULL, 8'hE5); // crystal pins keep pull-ups off
    wr(8'h01, 8'h77);
    st();
    `CHK("a dir", 8'h5A, port_a_direction)
    `CHK("b dir", 6'h15, port_b_direction)
    `CHK("b od", 6'h2A, port_b_open_drain)
    `CHK("pull up", 8'h1A, port_a_pullup_en)
    `CHK("pull dn", 1'b0, pin5_pulldown_en)
    rd(`FPSFR_IDX_PULL, 32'hE5);
    rd(`FPSFR_IDX_PBDIR, 32'h15);
    rd(`FPSFR_IDX_PBOD, 32'h2A);
    rd(8'h01, 32'h0);
    wr(`FPSFR_IDX_PULL, 8'h00);
    st();
    `CHK("pull up", 8'hDF, port_a_pullup_en)
    `CHK("pull dn", 1'b1, pin5_pulldown_en)
    $display("test rw done");
  endtask
  task automatic t_ps0;
    wr(`FPSFR_IDX_PS0, 8'h00);
    ps0_tick <= 1'b1;
    repeat (3) @(posedge hclk);
    ps0_tick <= 1'b0;
    rd(`FPSFR_IDX_PS0, 32'h02);
    wr(`FPSFR_IDX_PCON, 8'h1C);
    ps0_tick <= 1'b1;
    repeat (2) @(posedge hclk);
    ps0_tick <= 1'b0;
    `CHK("t0 run", 1'b0, timer_zero_run)
    rd(`FPSFR_IDX_PS0, 32'h02);
    $display("test prescaler done");
  endtask
  task automatic t_cmp;
    logic [3:0] vs, ps;
    for (int v = 0; v < 3; v++) begin
      vs = v == 0 ? 4'h0 : v == 1 ? 4'h1 : 4'hF;
      for (int p = 0; p < 5; p++) begin
        ps = p == 4 ? 4'hF : p[3:0];
        wr(`FPSFR_IDX_CMP, {ps, vs});
        st();
        `CHK("p2p", vs == 4'h0, pad_to_pad_mode)
        `CHK("ref", vs, cmp_ref_level)
        `CHK("non inv", ps < 4 ? 4'h1 << ps : 4'h0, cmp_noninv_pad)
        `CHK("inv", vs == 0 && ps < 4 ? 4'h1 << (ps ^ 4'h1) : 4'h0, cmp_inv_pad)
        rd(`FPSFR_IDX_CMP, {24'h0, ps, vs});
      end
    end
    $display("test comparator done");
  endtask
  task automatic t_pcon;
    for (int t = 0; t < 8; t++) begin
      wr(`FPSFR_IDX_PCON, {3'h1, t[2:0], 2'h0});
      st();
      `CHK("lv thr", t[2:0], low_voltage_threshold)
      rd(`FPSFR_IDX_PCON, {27'h1, t[2:0], 2'h0});
    end
    low_voltage_raw <= 1'b1;
    wr(`FPSFR_IDX_PCON, 8'h03);
    st();
    rd(`FPSFR_IDX_PCON, 32'h43);
    low_voltage_raw <= 1'b0;
    wr(`FPSFR_IDX_PCON, 8'h5D);
    st();
    rd(`FPSFR_IDX_PCON, 32'h1D);
    $display("test power control done");
  endtask
  task automatic t_gie;
    instr(1'b1, 1'b0);
    `CHK("gie", 1'b1, global_irq_enable)
    rd(`FPSFR_IDX_PCON, 32'h9D);
    instr(1'b1, 1'b1);
    `CHK("gie", 1'b1, global_irq_enable)
    instr(1'b0, 1'b1);
    `CHK("gie", 1'b0, global_irq_enable)
    rd(`FPSFR_IDX_PCON, 32'h1D);
    $display("test interrupt enable done");
  endtask
  task automatic t_t1;
    wr(`FPSFR_IDX_T1HI, 8'h30);
    wr(`FPSFR_IDX_T1LO, 8'h45);
    rd(`FPSFR_IDX_T1LO, 32'h45);
    rd(`FPSFR_IDX_T1HI, 32'h30);
    t1_run <= 1'b1;
    t1_tick <= 1'b1;
    repeat (3) @(posedge hclk);
    t1_tick <= 1'b0;
    rd(`FPSFR_IDX_T1LO, 32'h42);
    wr(`FPSFR_IDX_T1HI, 8'h10);
    wr(`FPSFR_IDX_T1LO, 8'h00);
    t1_tick <= 1'b1;
    @(posedge hclk);
    t1_tick <= 1'b0;
    rd(`FPSFR_IDX_T1LO, 32'hFF);
    rd(`FPSFR_IDX_T1HI, 32'h00);
    // Underflow restarts from the loaded value 2
    wr(`FPSFR_IDX_T1HI, 8'h00);
    wr(`FPSFR_IDX_T1LO, 8'h02);
    t1_tick <= 1'b1;
    repeat (4) @(posedge hclk);
    t1_tick <= 1'b0;
    rd(`FPSFR_IDX_T1LO, 32'h01);
    $display("test timer1 done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    results();
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    st();
    t_reset();
    t_rw();
    t_ps0();
    t_cmp();
    t_pcon();
    t_gie();
    t_t1();
    results();
  end
endmodule
